// ### hdl/addr_compare.sv
// Address comparator with ignore mask
module addr_compare
(
    // Reference and mask
    input  wire logic [31:0] ref_addr,
    input  wire logic [4:0]  mask,
    // Monitored access
    input  wire logic [31:0] acc_addr,
    input  wire logic        is_fetch,
    // Result
    output      logic        hit
);

    logic [31:0] ignore;

    // Fetches are halfword aligned, so bit 0 carries nothing even unmasked
    assign ignore = (mask == 5'h00) ? {31'h0000_0000, is_fetch}
                                    : ((32'h0000_0001 << mask) - 32'h0000_0001);
    assign hit    = ((acc_addr ^ ref_addr) & ~ignore) == 32'h0000_0000;

endmodule : addr_compare

// ### hdl/data_compare.sv
// Data value comparator on one byte lane, halfword or word
module data_compare
(
    // Reference and size
    input  wire logic [31:0] ref_data,
    input  wire logic [1:0]  size,
    // Monitored access
    input  wire logic [31:0] acc_data,
    input  wire logic [1:0]  addr_lo,
    // Result
    output      logic        hit
);

    logic [4:0] byte_sh;
    logic [4:0] half_sh;
    logic       byte_hit;
    logic       half_hit;
    logic       word_hit;

    // Reference is replicated, so the lane of the access is compared in place
    assign byte_sh  = {addr_lo, 3'h0};
    assign half_sh  = {addr_lo[1], 4'h0};
    assign byte_hit = acc_data[byte_sh +: 8] == ref_data[byte_sh +: 8];
    assign half_hit = acc_data[half_sh +: 16] == ref_data[half_sh +: 16];
    assign word_hit = acc_data == ref_data;
    assign hit      = (size == watch_pkg::size_byte) ? byte_hit :
                      (size == watch_pkg::size_half) ? half_hit :
                      (size == watch_pkg::size_word) ? word_hit : 1'b0;

endmodule : data_compare

// ### hdl/trace_watchpoint_comparator_function.sv
// Two-comparator watchpoint function control with AHB-Lite register slave
//
// The placing of the registers and the AHB-Lite slave port were decided locally.
`include "watch_defs.svh"

module trace_watchpoint_comparator_function
(
    // Clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output      logic [31:0] hrdata,
    output      logic        hreadyout,
    output      logic        hresp,
    // Monitored core accesses
    input  wire logic        acc_valid,
    input  wire logic [1:0]  acc_kind,
    input  wire logic [1:0]  acc_size,
    input  wire logic [31:0] acc_addr,
    input  wire logic [31:0] acc_data,
    // Match outputs
    output      logic        cmp0_match,
    output      logic        cmp1_match,
    output      logic        irq
);

    // Register state
    logic [31:0] comparator0_reference;
    logic [31:0] comparator1_reference;
    logic [4:0]  comparator0_ignore_mask;
    logic [4:0]  comparator1_ignore_mask;
    logic [3:0]  func0;
    logic [3:0]  func1;
    logic [3:0]  linked_comparator_index;
    logic [1:0]  data_compare_size;
    logic        data_value_compare_enable;
    logic        matched0;
    logic        matched1;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;

    // Bus state
    watch_pkg::bus_state_e state;
    watch_pkg::bus_state_e next_state;
    logic [11:0] dp_addr;
    logic        accept;
    logic        do_write;
    logic        do_read;
    logic [31:0] rdata_mux;

    // Decode
    logic        sel_comp0;
    logic        sel_mask0;
    logic        sel_fct0;
    logic        sel_comp1;
    logic        sel_mask1;
    logic        sel_fct1;
    logic        sel_status;
    logic        sel_imask;

    // Match path
    logic        is_fetch;
    logic        addr0_hit;
    logic        addr1_hit;
    logic        data_hit;
    logic        link_addr_hit;
    logic        cmp0_hit;
    logic        cmp1_hit;
    logic        cmp0_event;
    logic        cmp1_event;
    logic [3:0]  fct0_wr_link;

    function automatic logic action_hit(input logic [3:0] func, input logic [1:0] kind);
        logic r;
        r = 1'b0;
        case (watch_pkg::action_e'(func))
            watch_pkg::act_fetch:      r = kind == watch_pkg::kind_fetch;
            watch_pkg::act_read:       r = kind == watch_pkg::kind_read;
            watch_pkg::act_write:      r = kind == watch_pkg::kind_write;
            watch_pkg::act_read_write: r = kind != watch_pkg::kind_fetch;
            default:                   r = 1'b0;
        endcase
        return r;
    endfunction : action_hit

    function automatic logic [4:0] clamp_mask(input logic [4:0] v);
        return (v > `MASK_MAX) ? `MASK_MAX : v;
    endfunction : clamp_mask

    // Address decode in the data phase
    assign sel_comp0  = dp_addr == `OFS_COMP0;
    assign sel_mask0  = dp_addr == `OFS_MASK0;
    assign sel_fct0   = dp_addr == `OFS_FCT0;
    assign sel_comp1  = dp_addr == `OFS_COMP1;
    assign sel_mask1  = dp_addr == `OFS_MASK1;
    assign sel_fct1   = dp_addr == `OFS_FCT1;
    assign sel_status = dp_addr == `OFS_IRQ_STATUS;
    assign sel_imask  = dp_addr == `OFS_IRQ_MASK;

    // One wait state on reads keeps read-after-write coherent
    assign accept    = hsel && htrans[1] && hready && (state != watch_pkg::bus_rd_fetch);
    assign hreadyout = ce && (state != watch_pkg::bus_rd_fetch);
    assign hresp     = 1'b0;
    assign do_write  = ce && (state == watch_pkg::bus_write);
    assign do_read   = ce && (state == watch_pkg::bus_rd_fetch);

    always_comb
    begin
        next_state = state;
        unique case (state)
            watch_pkg::bus_rd_fetch:
                next_state = watch_pkg::bus_rd_give;
            watch_pkg::bus_idle, watch_pkg::bus_write, watch_pkg::bus_rd_give:
                next_state = !accept ? watch_pkg::bus_idle :
                             hwrite  ? watch_pkg::bus_write : watch_pkg::bus_rd_fetch;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state   <= watch_pkg::bus_idle;
            dp_addr <= 12'h000;
        end
        else if (ce)
        begin
            state <= next_state;
            if (accept)
                dp_addr <= haddr[11:0];
        end
    end

    // Read mux; unmapped offsets read zero, reserved bits zero
    assign rdata_mux =
        sel_comp0  ? comparator0_reference :
        sel_mask0  ? {27'h000_0000, comparator0_ignore_mask} :
        sel_fct0   ? {7'h00, matched0, 8'h00, linked_comparator_index,
                      data_compare_size, 1'b0, data_value_compare_enable,
                      4'h0, func0} :
        sel_comp1  ? comparator1_reference :
        sel_mask1  ? {27'h000_0000, comparator1_ignore_mask} :
        sel_fct1   ? {7'h00, matched1, 20'h0_0000, func1} :
        sel_status ? {30'h0000_0000, irq_status} :
        sel_imask  ? {30'h0000_0000, irq_mask} : `RST_WORD;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= `RST_WORD;
        else if (do_read)
            hrdata <= rdata_mux;
    end

    // Index values above one are not stored
    assign fct0_wr_link = (hwdata[15:13] == 3'h0) ? {3'h0, hwdata[`FCT_LINK_LSB]}
                                                  : linked_comparator_index;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            comparator0_reference   <= `RST_WORD;
            comparator1_reference   <= `RST_WORD;
            comparator0_ignore_mask <= `RST_MASK;
            comparator1_ignore_mask <= `RST_MASK;
            irq_mask                <= 2'h0;
        end
        else if (do_write)
        begin
            if (sel_comp0)
                comparator0_reference <= hwdata;
            if (sel_comp1)
                comparator1_reference <= hwdata;
            if (sel_mask0)
                comparator0_ignore_mask <= clamp_mask(hwdata[4:0]);
            if (sel_mask1)
                comparator1_ignore_mask <= clamp_mask(hwdata[4:0]);
            if (sel_imask)
                irq_mask <= hwdata[1:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            func0                     <= `RST_FUNC;
            func1                     <= `RST_FUNC;
            linked_comparator_index   <= `RST_FUNC;
            data_compare_size         <= `RST_SIZE;
            data_value_compare_enable <= 1'b0;
        end
        else if (do_write)
        begin
            if (sel_fct0)
            begin
                func0                     <= hwdata[3:0];
                linked_comparator_index   <= fct0_wr_link;
                data_compare_size         <= hwdata[`FCT_SIZE_LSB +: 2];
                data_value_compare_enable <= hwdata[`FCT_DVE_BIT];
            end
            // Comparator 1 keeps only its action; it has no data mode
            if (sel_fct1)
                func1 <= hwdata[3:0];
        end
    end

    // Comparators
    assign is_fetch = acc_kind == watch_pkg::kind_fetch;

    addr_compare u_addr0
    (
        .ref_addr (comparator0_reference),
        .mask     (comparator0_ignore_mask),
        .acc_addr (acc_addr),
        .is_fetch (is_fetch),
        .hit      (addr0_hit)
    );

    addr_compare u_addr1
    (
        .ref_addr (comparator1_reference),
        .mask     (comparator1_ignore_mask),
        .acc_addr (acc_addr),
        .is_fetch (is_fetch),
        .hit      (addr1_hit)
    );

    data_compare u_data0
    (
        .ref_data (comparator0_reference),
        .size     (data_compare_size),
        .acc_data (acc_data),
        .addr_lo  (acc_addr[1:0]),
        .hit      (data_hit)
    );

    // Access must also be of the programmed size to count as a data match
    assign link_addr_hit = linked_comparator_index[0] ? addr1_hit : addr0_hit;
    assign cmp0_hit      = data_value_compare_enable
                         ? (data_hit && link_addr_hit && (acc_size == data_compare_size))
                         : addr0_hit;
    assign cmp1_hit      = addr1_hit;
    assign cmp0_event    = ce && acc_valid && action_hit(func0, acc_kind) && cmp0_hit;
    assign cmp1_event    = ce && acc_valid && action_hit(func1, acc_kind) && cmp1_hit;

    // Sticky flags: a match in the clearing cycle wins over the read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            matched0   <= 1'b0;
            matched1   <= 1'b0;
            irq_status <= 2'h0;
            cmp0_match <= 1'b0;
            cmp1_match <= 1'b0;
        end
        else if (ce)
        begin
            matched0      <= cmp0_event || (matched0 && !(do_read && sel_fct0));
            matched1      <= cmp1_event || (matched1 && !(do_read && sel_fct1));
            irq_status[0] <= cmp0_event || (irq_status[0] && !(do_read && sel_status));
            irq_status[1] <= cmp1_event || (irq_status[1] && !(do_read && sel_status));
            cmp0_match    <= cmp0_event;
            cmp1_match    <= cmp1_event;
        end
    end

    assign irq = |(irq_status & irq_mask);

    // Checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    link_index_range_a : assert property (linked_comparator_index <= 4'h1)
        else $error("linked index holds a value above one");

    linked_addr_qualifies_a : assert property (
        cmp0_event && data_value_compare_enable && linked_comparator_index[0]
        |-> addr1_hit && data_hit)
        else $error("linked data match without comparator 1 address hit");

    size_selects_a : assert property (
        cmp0_event && data_value_compare_enable |-> acc_size == data_compare_size)
        else $error("data match at a size other than the programmed one");

    addr_mode_needs_a : assert property (
        cmp0_event && !data_value_compare_enable |-> addr0_hit)
        else $error("address mode match without address hit");

    cmp1_addr_only_a : assert property (cmp1_event |-> addr1_hit)
        else $error("comparator 1 matched without its address");

    disabled_no_match_a : assert property (func0 == 4'h0 |-> !cmp0_event)
        else $error("disabled comparator 0 matched");

    reserved_read_zero_a : assert property (
        do_read && sel_fct0 |=> hrdata[23:16] == 8'h00 && !hrdata[9] && hrdata[7:4] == 4'h0)
        else $error("reserved function bits read nonzero");

    sticky_set_read_a : assert property (
        cmp0_event |=> matched0 ##1 (matched0 || $past(do_read && sel_fct0)))
        else $error("match flag not held until read");

    read_clears_flag_a : assert property (
        do_read && sel_fct0 && !cmp0_event |=> !matched0)
        else $error("read did not clear match flag");

    mask_clamp_a : assert property (
        do_write && sel_mask0 && hwdata[4:0] > `MASK_MAX |=> comparator0_ignore_mask == `MASK_MAX)
        else $error("mask write above limit not clamped");

    type_gates_a : assert property (
        cmp0_event |-> action_hit(func0, acc_kind) ##1 cmp0_match)
        else $error("match without access type agreement");

    read_wait_state_a : assert property (
        accept && !hwrite && ce |=> !hreadyout)
        else $error("read answered without its wait state");

    // Stall holds every register, so a paused core loses no flag
    stall_freezes_a : assert property (
        !ce |=> $stable(func0) && $stable(matched0) && $stable(irq_status))
        else $error("state moved while the clock enable was low");

    status_read_clears_a : assert property (
        do_read && sel_status && !cmp0_event && !cmp1_event |=> irq_status == 2'h0)
        else $error("status read left a bit set");

    linked_data_c : cover property (cmp0_event && data_value_compare_enable
                                    && linked_comparator_index[0]);
    addr_match_c  : cover property (cmp1_event);
    flag_read_c   : cover property (do_read && sel_fct0 && matched0 ##1 hrdata[24]);
    irq_raise_c   : cover property (!irq ##1 irq);
    ce_stall_c    : cover property (!ce && acc_valid);

endmodule : trace_watchpoint_comparator_function

// ### hdl/watch_defs.svh
// Offsets, field positions, reset values and limits of the comparator function block
`ifndef WATCH_DEFS_SVH
`define WATCH_DEFS_SVH

// Byte offsets within the unit
`define OFS_COMP0      12'h020
`define OFS_MASK0      12'h024
`define OFS_FCT0       12'h028
`define OFS_COMP1      12'h030
`define OFS_MASK1      12'h034
`define OFS_FCT1       12'h038
`define OFS_IRQ_STATUS 12'h040
`define OFS_IRQ_MASK   12'h044

// Function register fields
`define FCT_MATCHED_BIT 24
`define FCT_LINK_LSB    12
`define FCT_SIZE_LSB    10
`define FCT_DVE_BIT     8

// Limits and reset values
`define MASK_MAX      5'h18
`define RST_WORD      32'h0000_0000
`define RST_MASK      5'h00
`define RST_FUNC      4'h0
`define RST_SIZE      2'h0

`endif

// ### hdl/watch_pkg.sv
// Types shared by the comparator function block
package watch_pkg;

    typedef enum logic [3:0] {
        act_disabled   = 4'h0,
        act_fetch      = 4'h4,
        act_read       = 4'h5,
        act_write      = 4'h6,
        act_read_write = 4'h7
    } action_e;

    typedef enum logic [1:0] {
        kind_fetch = 2'h0,
        kind_read  = 2'h1,
        kind_write = 2'h2
    } access_kind_e;

    typedef enum logic [1:0] {
        size_byte = 2'h0,
        size_half = 2'h1,
        size_word = 2'h2
    } data_size_e;

    typedef enum logic [3:0] {
        bus_idle     = 4'h1,
        bus_write    = 4'h2,
        bus_rd_fetch = 4'h4,
        bus_rd_give  = 4'h8
    } bus_state_e;

endpackage : watch_pkg

// ### test/core_access_model.sv
// Model of the monitored core access stream
module core_access_model
(
    // Clock
    input  wire logic        hclk,
    // Access stream
    output      logic        acc_valid,
    output      logic [1:0]  acc_kind,
    output      logic [1:0]  acc_size,
    output      logic [31:0] acc_addr,
    output      logic [31:0] acc_data
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        acc_valid = 1'b0;
        acc_kind  = 2'h3;
        acc_size  = 2'h3;
        acc_addr  = 32'h0000_0000;
        acc_data  = 32'h0000_0000;
    end

    // One access per call, held for one edge only
    task automatic send(input logic [1:0] kind, input logic [1:0] size,
                        input logic [31:0] addr, input logic [31:0] data);
        acc_valid <= 1'b1;
        acc_kind  <= kind;
        acc_size  <= size;
        acc_addr  <= addr;
        acc_data  <= data;
        @(posedge hclk);
        // Idle kind, address and data lines show inverted values so stale data cannot match
        acc_valid <= 1'b0;
        acc_kind  <= ~kind;
        acc_addr  <= ~addr;
        acc_data  <= ~data;
    endtask : send
endmodule : core_access_model

// ### test/trace_watchpoint_comparator_function_bench.sv
// Self-checking bench for the comparator function block
`include "watch_defs.svh"

module trace_watchpoint_comparator_function_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk;
    logic        hresetn;
    logic        ce;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        acc_valid;
    logic [1:0]  acc_kind;
    logic [1:0]  acc_size;
    logic [31:0] acc_addr;
    logic [31:0] acc_data;
    logic        cmp0_match;
    logic        cmp1_match;
    logic        irq;
    logic [31:0] rd;
    logic [3:0]  acts [4] = '{4'h0, 4'h4, 4'h5, 4'h6};
    int          err_count;
    int          cmp_count;

    always #5 hclk = ~hclk;

    trace_watchpoint_comparator_function u_dut
    (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .ce         (ce),
        .hsel       (hsel),
        .haddr      (haddr),
        .htrans     (htrans),
        .hwrite     (hwrite),
        .hsize      (hsize),
        .hwdata     (hwdata),
        .hready     (hreadyout),
        .hrdata     (hrdata),
        .hreadyout  (hreadyout),
        .hresp      (hresp),
        .acc_valid  (acc_valid),
        .acc_kind   (acc_kind),
        .acc_size   (acc_size),
        .acc_addr   (acc_addr),
        .acc_data   (acc_data),
        .cmp0_match (cmp0_match),
        .cmp1_match (cmp1_match),
        .irq        (irq)
    );

    core_access_model u_core
    (
        .hclk      (hclk),
        .acc_valid (acc_valid),
        .acc_kind  (acc_kind),
        .acc_size  (acc_size),
        .acc_addr  (acc_addr),
        .acc_data  (acc_data)
    );

    task automatic end_sim();
        if (err_count == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_sim

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : check

    // Bounded wait for hready sampled high at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 20)
            begin
                err_count++;
                $display("MISMATCH at %0t: bus wait timed out", $time);
                end_sim();
            end
            @(posedge hclk);
        end
    endtask : wait_ready

    task automatic ahb(input logic wr, input logic [11:0] ofs, input logic [31:0] wd);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= {20'h0_0000, ofs};
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask : ahb

    task automatic wr(input logic [11:0] ofs, input logic [31:0] wd);
        ahb(1'b1, ofs, wd);
    endtask : wr

    task automatic rd_chk(input logic [11:0] ofs, input logic [31:0] exp, input string what);
        ahb(1'b0, ofs, 32'h0000_0000);
        check(rd, exp, what);
        check({31'h0, hresp}, 32'h0000_0000, "hresp");
    endtask : rd_chk

    // Match pulses stand one cycle, so look at mid-cycle after the access
    task automatic acc_chk(input logic [1:0] kind, input logic [1:0] size,
                           input logic [31:0] addr, input logic [31:0] data,
                           input logic m0, input logic m1);
        u_core.send(kind, size, addr, data);
        @(negedge hclk);
        check({31'h0, cmp0_match}, {31'h0, m0}, "match0");
        check({31'h0, cmp1_match}, {31'h0, m1}, "match1");
        @(posedge hclk);
    endtask : acc_chk

    task automatic irq_chk(input logic exp);
        @(negedge hclk);
        check({31'h0, irq}, {31'h0, exp}, "irq");
        @(posedge hclk);
    endtask : irq_chk

    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        err_count = 0;
        cmp_count = 0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset state, reserved bits, refused index, clamp
        rd_chk(`OFS_FCT0, 32'h0000_0000, "fct0 reset");
        rd_chk(12'h100, 32'h0000_0000, "unmapped");
        wr(`OFS_FCT0, 32'hFFFF_19F6);
        rd_chk(`OFS_FCT0, 32'h0000_1906, "fct0 fields");
        wr(`OFS_FCT0, 32'h0000_2906);
        rd_chk(`OFS_FCT0, 32'h0000_1906, "index range");
        wr(`OFS_MASK0, 32'h0000_001F);
        rd_chk(`OFS_MASK0, 32'h0000_0018, "mask clamp");
        wr(`OFS_FCT1, 32'h0000_1D05);
        rd_chk(`OFS_FCT1, 32'h0000_0005, "fct1 fields");
        // Disabled, fetch, read and write actions against every access kind, address mode
        wr(`OFS_COMP0, 32'h2000_1000);
        for (int a = 0; a < 4; a++)
            for (int k = 0; k < 3; k++)
            begin
                wr(`OFS_FCT0, {28'h000_0000, acts[a]});
                acc_chk(2'(k), 2'h2, 32'h2000_1000, 32'h0, a > 0 && a - 1 == k,
                        1'b0);
            end
        irq_chk(1'b0);
        rd_chk(`OFS_FCT0, 32'h0100_0006, "flag set");
        rd_chk(`OFS_FCT0, 32'h0000_0006, "flag clear");
        acc_chk(watch_pkg::kind_write, 2'h2, 32'h20FF_FFFC, 32'h0, 1'b1, 1'b0);
        acc_chk(watch_pkg::kind_write, 2'h2, 32'h2100_0000, 32'h0, 1'b0, 1'b0);
        // Interrupt raised by unmasking, cleared by status read
        wr(`OFS_IRQ_MASK, 32'h0000_0001);
        irq_chk(1'b1);
        rd_chk(`OFS_IRQ_STATUS, 32'h0000_0001, "status");
        irq_chk(1'b0);
        // Linked data match: comparator 1 gives the address range
        wr(`OFS_COMP0, 32'h5A5A_5A5A);
        wr(`OFS_COMP1, 32'h3000_0000);
        wr(`OFS_MASK1, 32'h0000_0004);
        wr(`OFS_FCT1, 32'h0000_0000);
        wr(`OFS_FCT0, 32'h0000_1106);
        acc_chk(watch_pkg::kind_write, 2'h0, 32'h3000_0003, 32'h5A00_0000,
                1'b1, 1'b0);
        acc_chk(watch_pkg::kind_write, 2'h0, 32'h3000_0003, 32'h5B00_0000,
                1'b0, 1'b0);
        acc_chk(watch_pkg::kind_write, 2'h0, 32'h3000_0013, 32'h5A00_0000,
                1'b0, 1'b0);
        acc_chk(watch_pkg::kind_read, 2'h0, 32'h3000_0003, 32'h5A00_0000, 1'b0, 1'b0);
        wr(`OFS_FCT0, 32'h0000_1506);
        acc_chk(watch_pkg::kind_write, 2'h1, 32'h3000_0002, 32'h5A5A_0000, 1'b1, 1'b0);
        wr(`OFS_FCT0, 32'h0000_1906);
        acc_chk(watch_pkg::kind_write, 2'h2, 32'h3000_000C, 32'h5A5A_5A5A, 1'b1, 1'b0);
        acc_chk(watch_pkg::kind_write, 2'h2, 32'h3000_000C, 32'h5A5A_5A5B, 1'b0, 1'b0);
        // Comparator 1 on its own, address only
        wr(`OFS_FCT1, 32'h0000_0005);
        acc_chk(watch_pkg::kind_read, 2'h2, 32'h3000_0008, 32'h5A5A_5A5A,
                1'b0, 1'b1);
        rd_chk(`OFS_FCT1, 32'h0100_0005, "fct1 flag");
        rd_chk(`OFS_IRQ_STATUS, 32'h0000_0003, "status both");
        rd_chk(`OFS_IRQ_STATUS, 32'h0000_0000, "status clear");
        // Clock enable low: a matching access is ignored and the bus stalls
        ce <= 1'b0;
        acc_chk(watch_pkg::kind_read, 2'h2, 32'h3000_0008, 32'h0, 1'b0, 1'b0);
        check({31'h0, hreadyout}, 32'h0000_0000, "stall");
        ce <= 1'b1;
        rd_chk(`OFS_FCT1, 32'h0000_0005, "ce freeze");
        // Reset in mid-run returns the registers to zero
        hresetn <= 1'b0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rd_chk(`OFS_FCT0, 32'h0000_0000, "fct0 after reset");
        rd_chk(`OFS_MASK0, 32'h0000_0000, "mask0 after reset");
        end_sim();
    end
endmodule : trace_watchpoint_comparator_function_bench
